/* File: inc/ssca_consts.svh */
`ifndef SSCA_CONSTS_SVH
`define SSCA_CONSTS_SVH
// Field positions within the mode registers
`define SSCA_M0_LOCK_HI    7
`define SSCA_M0_LOCK_LO    3
`define SSCA_M1_LOCK_HI    4
`define SSCA_M1_LOCK_LO    3
`define SSCA_M0_OUT_EN     3
`define SSCA_M0_IN_EN      4
`define SSCA_M2_AUTO       0
// Alignment counter
`define SSCA_CNT_W         3
`define SSCA_CNT_LAST      3'h7
`define SSCA_CNT_RESET     3'h0
// Byte width and fifo size
`define SSCA_BYTE_W        8
`define SSCA_FIFO_DEPTH    32
`endif

/* File: inc/ssca_pkg.sv */
package ssca_pkg;
  typedef enum logic [1:0] {SSCA_IDLE, SSCA_SHIFT, SSCA_STALL} ssca_state_t;
endpackage

/* File: verilog/ssca_top.sv */
`timescale 1ns/1ps
`include "ssca_consts.svh"

module ssca_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_wdata,
  input  wire logic             i_wvalid,
  output logic                  o_wready,
  output logic [WIDTH-1:0]      o_rdata,
  output logic                  o_rvalid,
  input  wire logic             i_rready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wptr;
  logic [AW-1:0]    next_rptr;
  logic [AW:0]      next_count;
  logic             do_w;
  logic             do_r;

  // Pointer and count update
  always_comb begin
    do_w = i_wvalid && (count != (AW+1)'(DEPTH));
    do_r = i_rready && (count != '0);
    next_wptr = do_w ? wptr + 1'b1 : wptr;
    next_rptr = do_r ? rptr + 1'b1 : rptr;
    next_count = count + (AW+1)'(do_w) - (AW+1)'(do_r);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
  end

  // Storage has no reset
  always_ff @(posedge i_sys_clk) begin
    if (do_w) begin
      mem[wptr] <= i_wdata;
    end
  end

  assign o_wready = (count != (AW+1)'(DEPTH));
  assign o_rvalid = (count != '0);
  assign o_rdata  = mem[rptr];
endmodule

module ssca_top #(
  parameter int FIFO_DEPTH = `SSCA_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  // Mode registers
  input  wire logic [7:0] i_first_mode_register,
  input  wire logic [7:0] i_second_mode_register,
  input  wire logic [7:0] i_third_mode_register,
  // Output byte stream to the chain
  input  wire logic [7:0] i_out_data,
  input  wire logic       i_out_valid,
  output logic            o_out_ready,
  // Return byte stream from the chain
  output logic [7:0]      o_in_data,
  output logic            o_in_valid,
  input  wire logic       i_in_ready,
  // Serial scan pins
  input  wire logic       i_tdi,
  output logic            o_tck_en,
  output logic            o_tdo,
  // Status
  output logic [2:0]      o_bit_count,
  output logic            o_running
);
  // Return data synchroniser
  logic tdi_s1;
  logic tdi_s2;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tdi_s1 <= 1'b0;
      tdi_s2 <= 1'b0;
    end else begin
      tdi_s1 <= i_tdi;
      tdi_s2 <= tdi_s1;
    end
  end

  logic       out_en;
  logic       in_en;
  assign out_en = i_first_mode_register[`SSCA_M0_OUT_EN];
  assign in_en  = i_first_mode_register[`SSCA_M0_IN_EN];

  // Fifo on the return path
  logic [7:0] fifo_wdata;
  logic       fifo_wvalid;
  logic       fifo_wready;
  logic [7:0] fifo_rdata;
  logic       fifo_rvalid;
  logic       fifo_rready;

  ssca_fifo #(.WIDTH(`SSCA_BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .i_wdata   (fifo_wdata),
    .i_wvalid  (fifo_wvalid),
    .o_wready  (fifo_wready),
    .o_rdata   (fifo_rdata),
    .o_rvalid  (fifo_rvalid),
    .i_rready  (fifo_rready)
  );

  // Shift state
  ssca_pkg::ssca_state_t state;
  ssca_pkg::ssca_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [7:0] out_sh;
  logic [7:0] next_out_sh;
  logic       out_loaded;
  logic       next_out_loaded;
  logic [7:0] in_sh;
  logic [7:0] next_in_sh;
  logic       in_full;
  logic       next_in_full;
  logic       tck_en;
  logic       next_tck_en;
  logic       tdo;
  logic       next_tdo;
  logic       shift_en;
  logic       wrap;

  always_comb begin
    // Input fill status and modes make the shift enable
    // An empty output shifter stalls too when output is enabled, so loads then land at count zero
    shift_en = in_en || out_en;
    if (in_en && in_full) begin
      shift_en = 1'b0;
    end
    if (out_en && !out_loaded) begin
      shift_en = 1'b0;
    end
    wrap = shift_en && (cnt == `SSCA_CNT_LAST);
    next_state      = state;
    next_cnt        = cnt;
    next_out_sh     = out_sh;
    next_out_loaded = out_loaded;
    next_in_sh      = in_sh;
    next_in_full    = in_full && !fifo_wready;
    next_tck_en     = shift_en;
    next_tdo        = tdo;
    if (in_full && fifo_wready) begin
      next_in_full = 1'b0;
    end
    // Load the output shifter whenever it is empty, in any state
    if (!out_loaded && i_out_valid) begin
      next_out_sh     = i_out_data;
      next_out_loaded = 1'b1;
    end
    if (shift_en) begin
      next_cnt = cnt + 3'h1;
      if (out_en && out_loaded) begin
        // Bit position indexes the shifter: entry at three leaves 5 bits
        next_tdo = out_sh[cnt];
        if (wrap) begin
          next_out_loaded = 1'b0;
        end
      end
      if (in_en) begin
        next_in_sh = {tdi_s2, in_sh[7:1]};
        if (wrap) begin
          next_in_full = 1'b1;
        end
      end
    end
    case (state)
      ssca_pkg::SSCA_IDLE:  if (shift_en) next_state = ssca_pkg::SSCA_SHIFT;
      ssca_pkg::SSCA_SHIFT: if (!shift_en) next_state = ssca_pkg::SSCA_STALL;
      ssca_pkg::SSCA_STALL: begin
        if (shift_en) next_state = ssca_pkg::SSCA_SHIFT;
        else if (!in_en && !out_en) next_state = ssca_pkg::SSCA_IDLE;
      end
      default: next_state = ssca_pkg::SSCA_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state      <= ssca_pkg::SSCA_IDLE;
      cnt        <= `SSCA_CNT_RESET;
      out_sh     <= 8'h00;
      out_loaded <= 1'b0;
      in_sh      <= 8'h00;
      in_full    <= 1'b0;
      tck_en     <= 1'b0;
      tdo        <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      out_sh     <= next_out_sh;
      out_loaded <= next_out_loaded;
      in_sh      <= next_in_sh;
      in_full    <= next_in_full;
      tck_en     <= next_tck_en;
      tdo        <= next_tdo;
    end
  end

  assign fifo_wdata  = in_sh;
  assign fifo_wvalid = in_full;
  assign fifo_rready = i_in_ready;

  // Registered outputs
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_in_data   <= 8'h00;
      o_in_valid  <= 1'b0;
      o_out_ready <= 1'b0;
      o_running   <= 1'b0;
    end else begin
      o_in_data   <= fifo_rdata;
      o_in_valid  <= fifo_rvalid && !i_in_ready;
      o_out_ready <= !next_out_loaded;
      o_running   <= (next_state == ssca_pkg::SSCA_SHIFT);
    end
  end

  assign o_tck_en    = tck_en;
  assign o_tdo       = tdo;
  assign o_bit_count = cnt;

  // Checks
  a_tck_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    shift_en |=> o_tck_en) else $error("test clock not enabled");
  a_tck_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !shift_en |=> !o_tck_en) else $error("test clock not stopped");
  a_cnt_step: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    shift_en |=> cnt == $past(cnt) + 3'h1) else $error("count no step");
  a_cnt_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !shift_en |=> $stable(cnt)) else $error("count moved");
  a_wrap_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    wrap |=> cnt == 3'h0) else $error("no wrap");
  a_in_byte: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (wrap && in_en) |=> in_full) else $error("byte not marked");
  a_in_stall: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (in_en && in_full) |-> !shift_en) else $error("shift while full");
  a_tdi_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (shift_en && in_en) |=> in_sh[7] == $past(tdi_s2))
    else $error("tdi bit lost");
  a_five_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (out_en && out_loaded && shift_en && cnt == 3'h3) |=>
      (out_loaded && o_tdo == $past(out_sh[3])))
    else $error("output shifter dropped");
  c_wrap: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) wrap);
  c_stall: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    state == ssca_pkg::SSCA_STALL);
  c_byte_out: cover property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_in_valid);
endmodule

/* File: tb/ssca_chain_model.sv */
`timescale 1ns/1ps
// Chain of target scan cells on the gated test clock
module ssca_chain_model #(
  parameter int LEN = 4
) (
  input  wire logic i_sys_clk,
  input  wire logic i_tck_en,
  input  wire logic i_tdo,
  output logic      o_tdi
);
  logic           tck;
  logic           en_lat = 1'b0;
  logic [LEN-1:0] cells = '1;
  logic           out_q = 1'b1;
  // Enable is latched while the clock is low, so no runt pulse appears
  always @(i_sys_clk or i_tck_en) if (!i_sys_clk) en_lat = i_tck_en;
  assign tck = i_sys_clk & en_lat;
  // Capture on the test clock rise
  always @(posedge tck) cells <= {i_tdo, cells[LEN-1:1]};
  // Present on the fall; targets stay in shift, so the level holds
  always @(negedge tck) out_q <= cells[0];
  assign o_tdi = out_q;
endmodule

/* File: tb/tb_scan_shift_clock_alignment.sv */
`timescale 1ns/1ps
module tb_scan_shift_clock_alignment;
  logic       i_sys_clk, i_rstn, i_out_valid, i_in_ready, i_tdi;
  logic [7:0] i_first_mode_register, i_second_mode_register;
  logic [7:0] i_third_mode_register, i_out_data, o_in_data, last_byte, b;
  logic [2:0] o_bit_count, exp_cnt;
  logic       o_out_ready, o_in_valid, o_tck_en, o_tdo, o_running;
  logic [3:0] bit_q[$];
  int         fail_count, checked, seed, pops, i;
  // Clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  ssca_top dut_u (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_first_mode_register(i_first_mode_register),
    .i_second_mode_register(i_second_mode_register),
    .i_third_mode_register(i_third_mode_register),
    .i_out_data(i_out_data), .i_out_valid(i_out_valid),
    .o_out_ready(o_out_ready), .o_in_data(o_in_data),
    .o_in_valid(o_in_valid), .i_in_ready(i_in_ready), .i_tdi(i_tdi),
    .o_tck_en(o_tck_en), .o_tdo(o_tdo), .o_bit_count(o_bit_count),
    .o_running(o_running)
  );
  ssca_chain_model chain_u (
    .i_sys_clk(i_sys_clk), .i_tck_en(o_tck_en), .i_tdo(o_tdo),
    .o_tdi(i_tdi)
  );
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Offer a byte and note its bits from index first upward
  task automatic send(input logic [7:0] d, input int first);
    i_out_data  = d;
    i_out_valid = 1'b1;
    for (int j = first; j < 8; j++) bit_q.push_back({d[j], 3'(j)});
    do @(posedge i_sys_clk); while (o_out_ready !== 1'b1);
    #1;
  endtask
  // Pop up to n return bytes with a single-cycle strobe
  task automatic drain(input int n);
    pops = 0;
    repeat (n * 20) begin
      @(posedge i_sys_clk);
      if (o_in_valid === 1'b1 && pops < n) begin
        last_byte = o_in_data;
        pops++;
        #1 i_in_ready = 1'b1;
        @(posedge i_sys_clk);
        #1 i_in_ready = 1'b0;
      end
    end
    #1;
  endtask
  // Watch each test clock cycle: count sequence and serial bits
  always @(posedge i_sys_clk) begin
    if (i_rstn && o_tck_en === 1'b1) begin
      // The count seen has already stepped past the bit on tdo
      check(8'(o_bit_count), 8'(3'(exp_cnt + 3'h1)), "bit_count");
      check(8'(o_running), 8'h01, "running");
      exp_cnt <= exp_cnt + 3'h1;
      if (bit_q.size() > 0 &&
          3'(o_bit_count - 3'h1) === bit_q[0][2:0]) begin
        check(8'(o_tdo), 8'(bit_q[0][3]), "tdo");
        void'(bit_q.pop_front());
      end
    end
  end
  // Watchdog
  initial begin
    #100us;
    fail_count++;
    stop_test;
  end
  // Main sequence
  initial begin
    seed = 32'hae72;
    exp_cnt = 3'h0;
    {i_out_valid, i_in_ready, i_out_data, i_first_mode_register} = '0;
    i_second_mode_register = 8'($random(seed));
    i_third_mode_register  = 8'($random(seed));
    i_rstn = 1'b0;
    repeat (16) @(posedge i_sys_clk);
    #1 i_rstn = 1'b1;
    @(posedge i_sys_clk);
    // Both directions, back to back bytes
    #1 i_first_mode_register = 8'h18;
    for (i = 0; i < 12; i++) send(i < 6 ? 8'($random(seed)) : 8'hFF, 0);
    i_out_valid = 1'b0;
    drain(12);
    check(8'(pops), 8'h0C, "pops");
    check(last_byte, 8'hFF, "in_data");
    // Loaded output enabled while the counter holds three
    i_first_mode_register = 8'h10;
    b = 8'($random(seed));
    send(b, 8);
    i_out_valid = 1'b0;
    do @(posedge i_sys_clk);
    while (!(o_tck_en === 1'b1 && o_bit_count === 3'h2));
    #1 i_first_mode_register = 8'h18;
    for (i = 3; i < 8; i++) bit_q.push_back({b[i], 3'(i)});
    repeat (30) @(posedge i_sys_clk);
    check(8'(bit_q.size()), 8'h00, "tdo_bits");
    // Fill the return buffer until the test clock stops
    #1 i_first_mode_register = 8'h10;
    repeat (400) @(posedge i_sys_clk);
    repeat (8) begin
      @(posedge i_sys_clk);
      check(8'(o_tck_en), 8'h00, "tck_en");
      check(8'(o_running), 8'h00, "running_stall");
    end
    #1;
    drain(40);
    check(8'(pops >= 32), 8'h01, "fill");
    stop_test;
  end
endmodule
